/* rtl/reset_strap_pkg.sv */
// Constants, field layout and state type for the reset strap sampler.
// Assumes a single platform clock and word-aligned Avalon-MM byte addresses.
package reset_strap_pkg;
  // Strap field layout
  localparam int          STRAP_W       = 16;
  localparam int          PORT_W        = 3;
  localparam int          PORT_LSB      = 0;
  localparam int          PLAT_PLL_LSB  = 3;
  localparam int          PLAT_PLL_W    = 4;
  localparam int          CORE_PLL_LSB  = 7;
  localparam int          CORE_PLL_W    = 4;
  // Pins with a gated pull-up; both PLL ratio fields have none
  localparam logic [15:0] PULLUP_MASK   = 16'hf807;
  localparam logic [15:0] STRAP_RST     = 16'hffff;

  // Register map, byte addresses
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  OFS_DISABLE   = 4'h0;
  localparam logic [3:0]  OFS_STRAPS    = 4'h4;
  localparam logic [3:0]  OFS_STATUS    = 4'h8;
  localparam logic [2:0]  DISABLE_RST   = 3'h0;
  localparam int          STAT_RUN_BIT  = 8;

  // Platform clocks the pull-up stays on after hard reset release
  localparam int          CNT_W         = 3;
  localparam logic [2:0]  PULL_HOLD_CLKS = 3'h4;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_HOLD,
    ST_RUN
  } sampler_state_type;
endpackage

/* rtl/strap_pin_mux.sv */
// Output side of the multiplexed strap pins.
// Assumes the sampler decides when the pins may be driven.
`timescale 1ns/1ns
module strap_pin_mux (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_drive_en,
  input  wire logic [15:0] i_func_out,
  output logic      [15:0] o_strap_out,
  output logic      [15:0] o_strap_oe_n
);
  logic [15:0] out_ff;

  // Normal function value, registered toward the pad
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      out_ff <= 16'h0000;
    end else begin
      out_ff <= i_func_out;
    end
  end

  assign o_strap_out  = out_ff;
  // Driver released whenever the pins act as strap inputs
  assign o_strap_oe_n = {16{~i_drive_en}};
endmodule // strap_pin_mux

/* rtl/reset_strap_sampler.sv */
// Strap sampler: pin control, configuration latch, port gating and
// Avalon-MM register slave. Assumes the hard reset pin and the strap
// pins are synchronous to i_mclk and the pads resolve the tristate.
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
module reset_strap_sampler (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_hard_reset_in_n,
  input  wire logic [15:0] i_strap_pin,
  input  wire logic [15:0] i_func_out,
  output logic      [15:0] o_strap_out,
  output logic      [15:0] o_strap_oe_n,
  output logic             o_rx_en,
  output logic      [15:0] o_pullup_en,
  output logic      [15:0] o_cfg_straps,
  output logic      [2:0]  o_port_active,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest
);
  reset_strap_pkg::sampler_state_type state_ff;
  reset_strap_pkg::sampler_state_type nxt_state;
  logic [2:0]  hold_cnt_ff;
  logic [15:0] straps_ff;
  logic [2:0]  disable_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic        drive_en;
  logic        in_hold;
  logic        in_run;
  logic        accept;

  // Port active when the strap enables it and software does not disable it
  function automatic logic [2:0] port_gate(input logic [15:0] straps,
                                           input logic [2:0]  dis);
    port_gate = straps[reset_strap_pkg::PORT_LSB +: reset_strap_pkg::PORT_W]
                & ~dis;
  endfunction

  // Sampler sequence
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      reset_strap_pkg::ST_RESET: begin
        if (i_hard_reset_in_n) begin
          nxt_state = reset_strap_pkg::ST_HOLD;
        end
      end
      reset_strap_pkg::ST_HOLD: begin
        if (!i_hard_reset_in_n) begin
          nxt_state = reset_strap_pkg::ST_RESET;
        end else if (hold_cnt_ff
                     == reset_strap_pkg::PULL_HOLD_CLKS - 3'h1) begin
          nxt_state = reset_strap_pkg::ST_RUN;
        end
      end
      reset_strap_pkg::ST_RUN: begin
        if (!i_hard_reset_in_n) begin
          nxt_state = reset_strap_pkg::ST_RESET;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_ff <= reset_strap_pkg::ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pull-up hold counter
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      hold_cnt_ff <= 3'h0;
    end else if (state_ff == reset_strap_pkg::ST_HOLD) begin
      hold_cnt_ff <= hold_cnt_ff + 3'h1;
    end else begin
      hold_cnt_ff <= 3'h0;
    end
  end

  // Configuration latch, loaded only at the release edge
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      straps_ff <= reset_strap_pkg::STRAP_RST;
    end else if (state_ff == reset_strap_pkg::ST_RESET
                 && i_hard_reset_in_n) begin
      straps_ff <= i_strap_pin;
    end
  end

  assign in_hold  = (state_ff == reset_strap_pkg::ST_HOLD);
  assign in_run   = (state_ff == reset_strap_pkg::ST_RUN);
  // Pins driven only after the hold, never while hard reset is low
  assign drive_en = in_run && i_hard_reset_in_n;
  assign o_rx_en  = ~drive_en;
  // Pull-ups only on pins that have one, and only while receiving
  assign o_pullup_en = drive_en ? 16'h0000
                       : reset_strap_pkg::PULLUP_MASK;
  assign o_cfg_straps  = straps_ff;
  assign o_port_active = port_gate(straps_ff, disable_ff);

  strap_pin_mux u_pin_mux (
    .i_mclk       (i_mclk),
    .i_sys_rst    (i_sys_rst),
    .i_drive_en   (drive_en),
    .i_func_out   (i_func_out),
    .o_strap_out  (o_strap_out),
    .o_strap_oe_n (o_strap_oe_n)
  );

  // Avalon-MM slave: one wait state, then the answer
  assign accept            = (i_avs_read || i_avs_write) && ack_ff;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_ff;
  assign o_avs_readdata    = rdata_ff;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (i_avs_read || i_avs_write) && !ack_ff;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_avs_read && !ack_ff) begin
      unique case (i_avs_address)
        reset_strap_pkg::OFS_DISABLE: rdata_ff <= {29'h0, disable_ff};
        reset_strap_pkg::OFS_STRAPS:  rdata_ff <= {16'h0, straps_ff};
        reset_strap_pkg::OFS_STATUS: begin
          rdata_ff <= {23'h0, in_run, 5'h0, port_gate(straps_ff, disable_ff)};
        end
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Software disable register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      disable_ff <= reset_strap_pkg::DISABLE_RST;
    end else if (accept && i_avs_write && i_avs_byteenable[0]
                 && i_avs_address == reset_strap_pkg::OFS_DISABLE) begin
      disable_ff <= i_avs_writedata[2:0];
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence s_hold_entry;
    $rose(in_hold) ##0 i_hard_reset_in_n[*5];
  endsequence

  sequence s_hold_run;
    in_hold[*4] ##1 in_run;
  endsequence

  a_strap_input_mode: assert property (
    !i_hard_reset_in_n |-> (o_strap_oe_n == 16'hffff) && o_rx_en)
    else $error("Strap pins driven during hard reset");

  a_capture_value: assert property (
    (state_ff == reset_strap_pkg::ST_RESET && i_hard_reset_in_n)
    |=> o_cfg_straps == $past(i_strap_pin))
    else $error("Strap latch missed release value");

  a_hold_run_time: assert property (
    s_hold_entry |-> in_run)
    else $error("Pins not returned after pull-up hold");

  a_hold_sequence: assert property (
    $rose(in_hold) |-> s_hold_run or (##[0:4] !i_hard_reset_in_n))
    else $error("Hold phase ended early");

  a_pullup_rx_off: assert property (
    !o_rx_en |-> o_pullup_en == 16'h0000)
    else $error("Pull-up on with receiver off");

  a_pullup_on_reset: assert property (
    !i_hard_reset_in_n |=> o_pullup_en == reset_strap_pkg::PULLUP_MASK
                           || i_hard_reset_in_n)
    else $error("Pull-up missing during hard reset");

  a_pll_no_pullup: assert property (
    (o_pullup_en & ~reset_strap_pkg::PULLUP_MASK) == 16'h0000)
    else $error("Pull-up on PLL ratio strap");

  a_straps_stable: assert property (
    (i_hard_reset_in_n && $past(i_hard_reset_in_n) && !$rose(in_hold))
    |-> $stable(o_cfg_straps))
    else $error("Latched straps changed outside release");

  a_strap_veto: assert property (
    !o_cfg_straps[0] |-> !o_port_active[0])
    else $error("Strap-disabled port became active");

  a_sw_disable: assert property (
    (accept && i_avs_write && i_avs_byteenable[0] && i_avs_writedata[1]
     && i_avs_address == reset_strap_pkg::OFS_DISABLE)
    |=> !o_port_active[1]
        && (o_port_active[0]
            == (o_cfg_straps[0] && !$past(i_avs_writedata[0]))))
    else $error("Software disable not applied");

  a_bus_wait: assert property (
    $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("Read answer not after one wait state");
endmodule // reset_strap_sampler

/* tb/board_strap_model.sv */
// Board side of the strap pins: pull-downs, PLL strap drivers, pad level.
// Assumes the sampler's pad controls; purely combinational.
`timescale 1ns/1ns
module board_strap_model (
  input  wire logic [15:0] i_strap_out,
  input  wire logic [15:0] i_strap_oe_n,
  input  wire logic [15:0] i_pullup_en,
  input  wire logic [15:0] i_pull_low,
  input  wire logic [7:0]  i_pll_drive,
  output logic      [15:0] o_strap_pin
);
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      if (!i_strap_oe_n[b]) begin
        o_strap_pin[b] = i_strap_out[b];
      end else if (b >= 3 && b <= 10) begin
        o_strap_pin[b] = i_pll_drive[b-3];
      end else if (i_pull_low[b]) begin
        o_strap_pin[b] = 1'b0;
      end else if (i_pullup_en[b]) begin
        o_strap_pin[b] = 1'b1;
      end else begin
        o_strap_pin[b] = ~i_strap_out[b];
      end
    end
  end
endmodule // board_strap_model

/* tb/tb.sv */
// Bench for the strap sampler: hard reset cycles and register bus.
// Assumes one 10 MHz clock and the board model on the pins.
`timescale 1ns/1ns
module tb;
  logic        i_mclk;
  logic        i_sys_rst;
  logic        hard_n;
  logic [15:0] pins;
  logic [15:0] func;
  logic [15:0] oe_n;
  logic [15:0] sout;
  logic [15:0] pull;
  logic [15:0] cfg;
  logic [15:0] pl;
  logic [7:0]  pll;
  logic        rx_en;
  logic [2:0]  act;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        waitreq;
  int          failures;
  int          compares;

  reset_strap_sampler reset_strap_sampler_i (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hard_reset_in_n(hard_n),
    .i_strap_pin(pins), .i_func_out(func), .o_strap_out(sout),
    .o_strap_oe_n(oe_n), .o_rx_en(rx_en), .o_pullup_en(pull),
    .o_cfg_straps(cfg), .o_port_active(act), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq));

  board_strap_model board_strap_model_i (
    .i_strap_out(sout), .i_strap_oe_n(oe_n), .i_pullup_en(pull),
    .i_pull_low(pl), .i_pll_drive(pll), .o_strap_pin(pins));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, e);
    int n;
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    for (n = 0; n < 20; n++) begin
      @(posedge i_mclk);
      if (waitreq === 1'b0) break;
    end
    if (n == 20) begin
      failures++;
      conclude();
    end
    if (!w) check("readdata", e, rdata);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic hard_cycle(input logic [15:0] low, input logic [7:0] p);
    @(posedge i_mclk);
    hard_n <= 1'b0;
    pl <= low;
    pll <= p;
    repeat (3) @(posedge i_mclk);
    #1;
    check("oe_n in reset", 16'hffff, oe_n);
    check("rx_en in reset", 1'b1, rx_en);
    check("pullup in reset", reset_strap_pkg::PULLUP_MASK, pull);
    @(posedge i_mclk);
    hard_n <= 1'b1;
    @(posedge i_mclk);
    #1;
    check("cfg", (reset_strap_pkg::PULLUP_MASK & ~low) | {p, 3'h0},
          cfg);
    repeat (3) @(posedge i_mclk);
    #1;
    check("pullup hold", reset_strap_pkg::PULLUP_MASK, pull);
    @(posedge i_mclk);
    #1;
    check("oe_n run", 16'h0000, oe_n);
    check("rx_en run", 1'b0, rx_en);
    check("pullup run", 16'h0000, pull);
  endtask

  initial begin
    {hard_n, rd, wr, addr, wdata, failures, compares} = '0;
    i_sys_rst = 1'b1;
    func = 16'h3c3c;
    pl = 16'h0000;
    pll = 8'h00;
    repeat (6) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    hard_cycle(16'h0802, 8'h5a);
    check("strap_out", 16'h3c3c, sout);
    pl <= 16'hffff;
    func <= 16'h0000;
    bus(1'b0, reset_strap_pkg::OFS_STRAPS, 0, 32'h0000f2d5);
    check("cfg held", 16'hf2d5, cfg);
    bus(1'b0, reset_strap_pkg::OFS_DISABLE, 0, 0);
    check("active", 3'b101, act);
    bus(1'b1, reset_strap_pkg::OFS_DISABLE, 32'h1, 0);
    @(posedge i_mclk);
    #1;
    check("active sw off", 3'b100, act);
    bus(1'b1, reset_strap_pkg::OFS_DISABLE, 32'h0, 0);
    @(posedge i_mclk);
    #1;
    check("active strap off", 3'b101, act);
    bus(1'b0, reset_strap_pkg::OFS_STATUS, 0, 32'h00000105);
    bus(1'b0, 4'hc, 0, 0);
    bus(1'b1, reset_strap_pkg::OFS_DISABLE, 32'h7, 0);
    hard_cycle(16'h0000, 8'ha5);
    check("active all sw off", 3'b000, act);
    bus(1'b1, reset_strap_pkg::OFS_DISABLE, 32'h0, 0);
    @(posedge i_mclk);
    #1;
    check("active all on", 3'b111, act);
    conclude();
  end
endmodule // tb
